// ---- tmpc_defines.svh ----
// constants of the level, mismatch and phase timing block
`ifndef TMPC_DEFINES_SVH
`define TMPC_DEFINES_SVH
// register indices on the register port
`define TMPC_A_OVTH     4'h0
`define TMPC_A_OITH     4'h1
`define TMPC_A_CSUM     4'h2
`define TMPC_A_MISMTH   4'h3
`define TMPC_A_CAL0     4'h4
`define TMPC_A_CAL1     4'h5
`define TMPC_A_CAL2     4'h6
`define TMPC_A_STAT0    4'h7
`define TMPC_A_STAT1    4'h8
`define TMPC_A_IMSK2    4'h9
`define TMPC_A_PHSTAT   4'ha
`define TMPC_A_CFG2     4'hb
// field positions
`define TMPC_B_SDONE    17
`define TMPC_B_OCUR     17
`define TMPC_B_OVOL     18
`define TMPC_B_MISM     20
`define TMPC_B_EXTREF   0
`define TMPC_B_OVPH     9
`define TMPC_B_OIPH     3
// reset values and levels
`define TMPC_FULL_SCALE 24'h5a7540
`define TMPC_LVL_RST    24'h5a7540
`define TMPC_MISM_RST   24'h000000
`define TMPC_CAL_RST    10'h000
`define TMPC_CAL_SPLIT  10'h200
`define TMPC_ADV_MAX    10'h17f
// step clock: 1.024 MHz out of 100 MHz by fractional accumulation
`define TMPC_STEP_NS    0.976
`define TMPC_SYS_KHZ    100000
`define TMPC_STEP_KHZ   1024
`endif

// ---- tmpc_pkg.sv ----
// types shared by the level, mismatch and phase timing block
package tmpc_pkg;
  // sample pipeline states
  typedef enum logic [2:0] {
    TMPC_IDLE = 3'b001,
    TMPC_SUM  = 3'b010,
    TMPC_CMP  = 3'b100
  } tmpc_state_e;
  // power modes
  typedef enum logic [1:0] {
    TMPC_PM_NORMAL = 2'h0,
    TMPC_PM_RED1   = 2'h1,
    TMPC_PM_RED2   = 2'h2,
    TMPC_PM_RED3   = 2'h3
  } tmpc_pmode_e;
  typedef logic [23:0] tmpc_smp_t;
endpackage

// ---- tmpc_mem_if.sv ----
// carrier between the block and one voltage delay memory
`timescale 1ns/1ps
interface tmpc_mem_if #(
  parameter int W = 24,
  parameter int D = 512
);
  logic                 ce;     // freeze when low
  logic                 we;     // write and read strobe
  logic [$clog2(D)-1:0] waddr;  // newest entry
  logic [$clog2(D)-1:0] raddr;  // delayed entry
  logic [W-1:0]         wdata;  // live voltage sample
  logic [W-1:0]         rdata;  // registered delayed sample
  modport ctl (output ce, we, waddr, raddr, wdata, input rdata);
  modport mem (input ce, we, waddr, raddr, wdata, output rdata);
endinterface

// ---- tmpc_delay_mem.sv ----
// delay line memory for one voltage path, registered read
`timescale 1ns/1ps
module tmpc_delay_mem #(
  parameter int W = 24,
  parameter int D = 512
) (
  input  wire logic sys_clk,
  tmpc_mem_if.mem   m
);
  logic [W-1:0] ram [D];  // no reset: contents settle within D steps
  logic [W-1:0] rdata_r;
  logic [W-1:0] rdata_nxt;

  ////////////////////////////////////////////////////////////////////
  // read next value, held while idle
  always_comb begin
    rdata_nxt = rdata_r;
    if (m.ce && m.we) begin
      rdata_nxt = ram[m.raddr];
    end
  end

  // write port and read register
  always_ff @(posedge sys_clk) begin
    if (m.ce && m.we) begin
      ram[m.waddr] <= m.wdata;
    end
    rdata_r <= rdata_nxt;
  end

  assign m.rdata = rdata_r;
endmodule

// ---- tmpc_top.sv ----
// level supervision, neutral mismatch, phase timing and reference select
`timescale 1ns/1ps
`include "tmpc_defines.svh"
module tmpc_top #(
  parameter int DEPTH = 512
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_rvalid,
  input  wire logic [1:0]        power_mode,
  input  wire logic              smp_valid,
  input  wire logic [2:0][23:0]  phase_voltage_sample,
  input  wire logic [23:0]       phase_a_current_sample,
  input  wire logic [23:0]       phase_b_current_sample,
  input  wire logic [23:0]       phase_c_current_sample,
  input  wire logic [23:0]       neutral_current_sample,
  output logic      [2:0][23:0]  phase_voltage_aligned,
  output logic                   second_interrupt_output_n,
  output logic                   external_reference_select
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [9:0] DMAX = 10'(DEPTH - 1);

  ////////////////////////////////////////////////////////////////////
  // control registers
  tmpc_pkg::tmpc_smp_t ovth_r, ovth_nxt;       // overvoltage_threshold
  tmpc_pkg::tmpc_smp_t oith_r, oith_nxt;       // overcurrent_threshold
  tmpc_pkg::tmpc_smp_t mismth_r, mismth_nxt;   // sum_mismatch_threshold
  logic [2:0][9:0]     cal_r, cal_nxt;         // phase_timing_cal a..c
  logic [31:0]         imsk_r, imsk_nxt;       // second_interrupt_mask
  logic                extref_r, extref_nxt;   // second_config_register bit
  logic wr_hit;

  assign wr_hit = ce && reg_wr;

  // register writes
  always_comb begin
    ovth_nxt   = ovth_r;
    oith_nxt   = oith_r;
    mismth_nxt = mismth_r;
    cal_nxt    = cal_r;
    imsk_nxt   = imsk_r;
    extref_nxt = extref_r;
    if (wr_hit) begin
      case (reg_addr)
        `TMPC_A_OVTH:   ovth_nxt   = reg_wdata[23:0];
        `TMPC_A_OITH:   oith_nxt   = reg_wdata[23:0];
        `TMPC_A_MISMTH: mismth_nxt = reg_wdata[23:0];
        `TMPC_A_CAL0:   cal_nxt[0] = reg_wdata[9:0];
        `TMPC_A_CAL1:   cal_nxt[1] = reg_wdata[9:0];
        `TMPC_A_CAL2:   cal_nxt[2] = reg_wdata[9:0];
        `TMPC_A_IMSK2:  imsk_nxt   = reg_wdata;
        `TMPC_A_CFG2: begin
          // only taken in normal mode, kept through reduced modes
          if (power_mode == tmpc_pkg::TMPC_PM_NORMAL) begin
            extref_nxt = reg_wdata[`TMPC_B_EXTREF];
          end
        end
        default: ;  // status words are cleared below; read-only or unmapped: ignored
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ovth_r   <= `TMPC_LVL_RST;
      oith_r   <= `TMPC_LVL_RST;
      mismth_r <= `TMPC_MISM_RST;
      cal_r    <= {3{`TMPC_CAL_RST}};
      imsk_r   <= 32'h0000_0000;
      extref_r <= 1'b0;
    end else begin
      ovth_r   <= ovth_nxt;
      oith_r   <= oith_nxt;
      mismth_r <= mismth_nxt;
      cal_r    <= cal_nxt;
      imsk_r   <= imsk_nxt;
      extref_r <= extref_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // level detection on each sample strobe
  logic [2:0] ovl_hit, ocl_hit;
  logic [2:0][23:0] cur;
  assign cur = {phase_c_current_sample, phase_b_current_sample,
                phase_a_current_sample};

  // magnitude of a signed sample; 0x800000 still fits unsigned
  function automatic logic [23:0] mag24(input logic [23:0] v);
    mag24 = v[23] ? 24'(-v) : v;
  endfunction

  // full scale mutes, zero forces, otherwise strictly above
  function automatic logic over(input logic [23:0] v, input logic [23:0] th);
    over = (th != `TMPC_FULL_SCALE) &&
           ((th == 24'h000000) || (mag24(v) > th));
  endfunction

  for (genvar p = 0; p < 3; p++) begin : g_lvl
    assign ovl_hit[p] = over(phase_voltage_sample[p], ovth_r);
    assign ocl_hit[p] = over(cur[p], oith_r);
  end

  ////////////////////////////////////////////////////////////////////
  // sum and mismatch pipeline
  tmpc_pkg::tmpc_state_e st_r, st_nxt;
  logic [27:0] csum_r, csum_nxt;  // phase_current_sum
  logic [23:0] nsmp_r, nsmp_nxt;  // neutral from the same period
  logic        take, mism_hit;
  logic [27:0] sum_calc, mag_sum, mag_neu, diff, th28;

  assign take = ce && smp_valid && (st_r == tmpc_pkg::TMPC_IDLE);
  // sign-extended sum cannot overflow 28 bits
  assign sum_calc = {{4{phase_a_current_sample[23]}}, phase_a_current_sample}
                  + {{4{phase_b_current_sample[23]}}, phase_b_current_sample}
                  + {{4{phase_c_current_sample[23]}}, phase_c_current_sample};
  assign mag_sum = csum_r[27] ? 28'(-csum_r) : csum_r;
  assign mag_neu = {4'h0, mag24(nsmp_r)};
  assign diff = (mag_sum > mag_neu) ? (mag_sum - mag_neu) : (mag_neu - mag_sum);
  assign th28 = {{4{mismth_r[23]}}, mismth_r};
  // zero or negative threshold always fires
  assign mism_hit = mismth_r[23] || (mismth_r == 24'h000000)
                 || (diff > th28);

  // one sum per strobe, compare two cycles later
  always_comb begin
    st_nxt   = st_r;
    csum_nxt = csum_r;
    nsmp_nxt = nsmp_r;
    if (ce) begin
      case (st_r)
        tmpc_pkg::TMPC_IDLE: begin
          if (smp_valid) begin
            csum_nxt = sum_calc;
            nsmp_nxt = neutral_current_sample;
            st_nxt   = tmpc_pkg::TMPC_SUM;
          end
        end
        tmpc_pkg::TMPC_SUM: st_nxt = tmpc_pkg::TMPC_CMP;
        tmpc_pkg::TMPC_CMP: st_nxt = tmpc_pkg::TMPC_IDLE;
        default:            st_nxt = tmpc_pkg::TMPC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r   <= tmpc_pkg::TMPC_IDLE;
      csum_r <= 28'h0000000;
      nsmp_r <= 24'h000000;
    end else begin
      st_r   <= st_nxt;
      csum_r <= csum_nxt;
      nsmp_r <= nsmp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear, a set in the same cycle wins
  logic [31:0] stat0_r, stat0_nxt, stat1_r, stat1_nxt;
  logic [31:0] phst_r, phst_nxt, clr1;
  logic        irq_n_r, irq_n_nxt;

  assign clr1 = (wr_hit && reg_addr == `TMPC_A_STAT1) ? reg_wdata : 32'h0;

  always_comb begin
    stat0_nxt = stat0_r;
    stat1_nxt = stat1_r & ~clr1;
    phst_nxt  = phst_r;
    if (wr_hit && reg_addr == `TMPC_A_STAT0) begin
      stat0_nxt = stat0_r & ~reg_wdata;
    end
    if (clr1[`TMPC_B_OVOL]) phst_nxt[`TMPC_B_OVPH+:3] = 3'b000;
    if (clr1[`TMPC_B_OCUR]) phst_nxt[`TMPC_B_OIPH+:3] = 3'b000;
    if (take) begin
      stat0_nxt[`TMPC_B_SDONE] = 1'b1;
      if (|ovl_hit) stat1_nxt[`TMPC_B_OVOL] = 1'b1;
      if (|ocl_hit) stat1_nxt[`TMPC_B_OCUR] = 1'b1;
      phst_nxt[`TMPC_B_OVPH+:3] = phst_nxt[`TMPC_B_OVPH+:3] | ovl_hit;
      phst_nxt[`TMPC_B_OIPH+:3] = phst_nxt[`TMPC_B_OIPH+:3] | ocl_hit;
    end
    if (ce && st_r == tmpc_pkg::TMPC_CMP && mism_hit) begin
      stat1_nxt[`TMPC_B_MISM] = 1'b1;
    end
    // interrupt follows the status it will show
    irq_n_nxt = ~|(stat1_nxt & imsk_nxt);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stat0_r <= 32'h0;
      stat1_r <= 32'h0;
      phst_r  <= 32'h0;
      irq_n_r <= 1'b1;
    end else if (ce) begin
      stat0_r <= stat0_nxt;
      stat1_r <= stat1_nxt;
      phst_r  <= phst_nxt;
      irq_n_r <= irq_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // step clock and voltage delay lines
  logic [16:0]   acc_r, acc_nxt;  // fractional step accumulator
  logic          tick;
  logic [AW-1:0] wp_r, wp_nxt;
  logic [2:0][23:0] al_r, al_nxt;
  logic [16:0]   acc_sum;
  logic [2:0][23:0] mem_rd;       // registered delay line outputs

  assign acc_sum = acc_r + 17'(`TMPC_STEP_KHZ);
  assign tick = acc_sum >= 17'(`TMPC_SYS_KHZ);

  // one write per step, always three taps on the same pointer
  always_comb begin
    acc_nxt = acc_r;
    wp_nxt  = wp_r;
    al_nxt  = al_r;
    if (ce) begin
      acc_nxt = tick ? 17'(acc_sum - 17'(`TMPC_SYS_KHZ)) : acc_sum;
      if (tick) wp_nxt = wp_r + 1'b1;
    end
    if (ce) al_nxt = mem_rd;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_r <= 17'h00000;
      wp_r  <= '0;
      al_r  <= '0;
    end else begin
      acc_r <= acc_nxt;
      wp_r  <= wp_nxt;
      al_r  <= al_nxt;
    end
  end

  tmpc_mem_if #(.W(24), .D(DEPTH)) mi [3] ();

  // nominal lag equals the largest advance, so advances shorten it;
  // out-of-span codes clamp, which the host must avoid
  for (genvar p = 0; p < 3; p++) begin : g_dly
    logic [9:0] taps;
    always_comb begin
      if (cal_r[p] < `TMPC_CAL_SPLIT) begin
        taps = (cal_r[p] > `TMPC_ADV_MAX) ? 10'h000
             : 10'(`TMPC_ADV_MAX - cal_r[p]);
      end else begin
        taps = `TMPC_ADV_MAX + (cal_r[p] - `TMPC_CAL_SPLIT);
        if (taps > DMAX) taps = DMAX;
      end
    end
    assign mi[p].ce    = ce;
    assign mi[p].we    = tick;
    assign mi[p].waddr = wp_r;
    // minus one: the slot at the pointer is overwritten this step
    assign mi[p].raddr = AW'(wp_r - AW'(taps) - 1'b1);
    assign mem_rd[p]   = mi[p].rdata;
    assign mi[p].wdata = phase_voltage_sample[p];
    tmpc_delay_mem #(.W(24), .D(DEPTH)) u_mem (
      .sys_clk (sys_clk),
      .m       (mi[p])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // register reads, padded with zeros above each field, the mismatch threshold first sign-extended to 28 bits
  logic [31:0] rd_r, rd_nxt;
  logic        rv_r, rv_nxt;

  always_comb begin
    rd_nxt = rd_r;
    rv_nxt = 1'b0;
    if (ce && reg_rd) begin
      rv_nxt = 1'b1;
      case (reg_addr)
        `TMPC_A_OVTH:   rd_nxt = {8'h00, ovth_r};
        `TMPC_A_OITH:   rd_nxt = {8'h00, oith_r};
        `TMPC_A_CSUM:   rd_nxt = {4'h0, csum_r};
        `TMPC_A_MISMTH: rd_nxt = {4'h0, th28};
        `TMPC_A_CAL0:   rd_nxt = {22'h0, cal_r[0]};
        `TMPC_A_CAL1:   rd_nxt = {22'h0, cal_r[1]};
        `TMPC_A_CAL2:   rd_nxt = {22'h0, cal_r[2]};
        `TMPC_A_STAT0:  rd_nxt = stat0_r;
        `TMPC_A_STAT1:  rd_nxt = stat1_r;
        `TMPC_A_IMSK2:  rd_nxt = imsk_r;
        `TMPC_A_PHSTAT: rd_nxt = phst_r;
        `TMPC_A_CFG2:   rd_nxt = {31'h0, extref_r};
        default:        rd_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_r <= 32'h0;
      rv_r <= 1'b0;
    end else begin
      rd_r <= rd_nxt;
      rv_r <= ce ? rv_nxt : rv_r;
    end
  end

  assign reg_rdata                 = rd_r;
  assign reg_rvalid                = rv_r;
  assign phase_voltage_aligned     = al_r;
  assign second_interrupt_output_n = irq_n_r;
  assign external_reference_select = extref_r;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  ovl_phase_set_a: assert property (take && ovl_hit[0]
    |=> stat1_r[`TMPC_B_OVOL] && phst_r[`TMPC_B_OVPH]) else $error("overvoltage flags not set");
  full_scale_mute_a: assert property (oith_r == `TMPC_FULL_SCALE
    |-> ocl_hit == 3'b000) else $error("full scale threshold reported");
  zero_level_a: assert property (take && oith_r == 24'h000000
    |=> stat1_r[`TMPC_B_OCUR] && phst_r[`TMPC_B_OIPH+:3] == 3'b111)
    else $error("zero threshold not continuous");
  sum_value_a: assert property (take
    |=> csum_r == 28'($signed($past(phase_a_current_sample)) +
        $signed($past(phase_b_current_sample)) +
        $signed($past(phase_c_current_sample)))) else $error("sum wrong");
  sdone_set_a: assert property (take |=> stat0_r[`TMPC_B_SDONE])
    else $error("data ready not set");
  mism_flag_a: assert property (take ##2
    (ce && st_r == tmpc_pkg::TMPC_CMP && mism_hit) |=> stat1_r[`TMPC_B_MISM])
    else $error("mismatch not flagged");
  mism_irq_a: assert property (stat1_r[`TMPC_B_MISM] && imsk_r[`TMPC_B_MISM]
    |-> !second_interrupt_output_n) else $error("irq not low");
  mism_clear_a: assert property (wr_hit && reg_addr == `TMPC_A_STAT1 &&
    reg_wdata == 32'h0010_0000 && st_r == tmpc_pkg::TMPC_IDLE &&
    (imsk_r & 32'hffef_ffff) == 32'h0000_0000
    |=> !stat1_r[`TMPC_B_MISM] && second_interrupt_output_n)
    else $error("mismatch not cleared");
  neg_thresh_a: assert property (take ##2
    (ce && st_r == tmpc_pkg::TMPC_CMP && mismth_r[23]) |=> stat1_r[`TMPC_B_MISM])
    else $error("negative threshold ignored");
  csum_pad_a: assert property (ce && reg_rd && reg_addr == `TMPC_A_CSUM
    |=> reg_rdata[31:28] == 4'h0 && reg_rvalid) else $error("sum not padded");

  ovl_seen_c:  cover property (take && |ovl_hit ##1 !second_interrupt_output_n);
  mism_seen_c: cover property (st_r == tmpc_pkg::TMPC_CMP && ce && mism_hit);
  clear_c:     cover property (stat1_r[`TMPC_B_MISM] ##1 !stat1_r[`TMPC_B_MISM]);
  step_c:      cover property (tick ##[1:200] tick);
endmodule

// ---- tmpc_host_model.sv ----
// host model driving the register port of the block
`timescale 1ns/1ps
module tmpc_host_model (
  input  wire logic        sys_clk,
  input  wire logic        reg_rvalid,
  input  wire logic [31:0] reg_rdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [3:0]  reg_addr,
  output logic      [31:0] reg_wdata
);
  ////////////////////////////////////////
  // idle levels from time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
  end
  ////////////////////////////////////////
  // one write pulse; data inverted after so a stale word never looks valid
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // read pulse, then a bounded wait for the answer
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    while (reg_rvalid !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    // no answer leaves an unknown so the compare fails
    d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hxxxxxxxx;
  endtask
  // flags are cleared by writing ones to the second status word
  task automatic clear_status(input logic [31:0] bits);
    wr(4'h8, bits);
  endtask
  // step count to code: lead as magnitude, lag plus 512
  function automatic logic [9:0] cal_code(input int steps);
    int s;
    s = (steps < -383) ? -383 : (steps > 63) ? 63 : steps;
    return (s <= 0) ? 10'(-s) : 10'(s + 512);
  endfunction
  // 24-bit values travel in the low bits of a 32-bit word
  function automatic logic [31:0] word24(input logic [23:0] v);
    return {8'h00, v};
  endfunction
endmodule

// ---- test_threshold_mismatch_phase_cal.sv ----
// self-checking bench for the level, mismatch and phase timing block
`timescale 1ns/1ps
module test_threshold_mismatch_phase_cal;
  localparam int FS = 24'h5a7540;      // full-scale filter output
  logic             sys_clk;
  logic             resetn;
  logic             ce;                // dropped once to test the freeze
  logic             reg_wr, reg_rd;
  logic [3:0]       reg_addr;
  logic [31:0]      reg_wdata, reg_rdata;
  logic             reg_rvalid;
  logic [1:0]       power_mode;
  logic             smp_valid;
  logic [2:0][23:0] vs;                // voltage samples a, b, c
  logic [3:0][23:0] cs;                // currents a, b, c, neutral
  logic             irq_n, extref;
  logic [2:0][23:0] al;                // delayed voltages from the block
  int               error_cnt, checked;
  logic [31:0]      rng;               // xorshift state
  logic [23:0]      lvl;               // level threshold under test
  int               steps [3] = '{-383, 63, -57};
  logic [23:0]      mt [4] = '{24'h0, 24'hfffff0, 24'h001000, 24'h7fffff};
  // reference model state
  logic [23:0]      ovth, oith, mthr;
  logic [27:0]      sum28;
  logic [9:0]       cal [3];
  logic [31:0]      st0, st1, imsk, phst;
  logic             cfg;
  ////////////////////////////////////////
  tmpc_top DUT (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .power_mode(power_mode), .smp_valid(smp_valid),
    .phase_voltage_sample(vs), .phase_a_current_sample(cs[0]),
    .phase_b_current_sample(cs[1]), .phase_c_current_sample(cs[2]),
    .neutral_current_sample(cs[3]), .phase_voltage_aligned(al),
    .second_interrupt_output_n(irq_n), .external_reference_select(extref));
  tmpc_host_model host (
    .sys_clk(sys_clk), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic int ab(input int x);
    return (x < 0) ? -x : x;
  endfunction
  // signed value within +-lim
  function automatic int rnd(input int lim);
    int r;
    r = int'(xs() % (lim + 1));
    return ((xs() & 32'h1) != 0) ? -r : r;
  endfunction
  function automatic int sx(input logic [23:0] v);
    return int'($signed(v));
  endfunction
  // zero forces, full scale never, else strictly above
  function automatic bit lv(input int x, input logic [23:0] th);
    if (th == 24'h0) return 1'b1;
    if (th == 24'(FS)) return 1'b0;
    return ab(x) > int'(th);
  endfunction
  function automatic logic [31:0] exp_reg(input int a);
    case (a)
      0:       return {8'h00, ovth};
      1:       return {8'h00, oith};
      2:       return {4'h0, sum28};
      3:       return {4'h0, 28'(sx(mthr))};
      4, 5, 6: return {22'h0, cal[a-4]};
      7:       return st0;
      8:       return st1;
      9:       return imsk;
      10:      return phst;
      11:      return {31'h0, cfg};
      default: return 32'h0;
    endcase
  endfunction
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [3:0] a);
    logic [31:0] d;
    host.rd(a, d);
    chk(d, exp_reg(a));
  endtask
  // write through the host and mirror it in the model
  task automatic w(input int a, input logic [31:0] d);
    if (a == 8) host.clear_status(d);
    else host.wr(4'(a), d);
    #1;
    case (a)
      0: ovth = d[23:0];
      1: oith = d[23:0];
      3: mthr = d[23:0];
      4, 5, 6: cal[a-4] = d[9:0];
      7: st0 = st0 & ~d;
      8: begin
        st1 = st1 & ~d;
        if (d[18]) phst[11:9] = 3'h0;
        if (d[17]) phst[5:3] = 3'h0;
      end
      9: imsk = d;
      11: if (power_mode == 2'h0) cfg = d[0];
      default: ;
    endcase
  endtask
  // one sample set; near puts neutral close to the phase sum
  task automatic smp(input bit near);
    int v[3];
    int c[3];
    int s;
    int n;
    for (int i = 0; i < 3; i++) begin
      v[i] = rnd(FS);
      c[i] = near ? rnd(FS / 3) : rnd(FS);
    end
    if (!near && rng[1]) v[0] = int'(ovth);
    s = c[0] + c[1] + c[2];
    n = near ? ab(s) + rnd(16'h2000) : rnd(16'h0fff);
    if (near && rng[2]) n = -n;
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      vs[i] <= v[i][23:0];
      cs[i] <= c[i][23:0];
    end
    cs[3] <= n[23:0];
    smp_valid <= 1'b1;
    @(posedge sys_clk);
    smp_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 3; i++) begin
      if (lv(v[i], ovth)) {st1[18], phst[9+i]} = 2'b11;
      if (lv(c[i], oith)) {st1[17], phst[3+i]} = 2'b11;
    end
    st0[17] = 1'b1;
    sum28 = s[27:0];
    // zero or negative threshold fires even on an exact match
    if (sx(mthr) <= 0 || ab(ab(s) - ab(n)) > sx(mthr)) st1[20] = 1'b1;
    chk({31'h0, irq_n}, {31'h0, (st1 & imsk) == 32'h0});
    rd_chk(4'h8);
    rd_chk(4'ha);
    rd_chk(4'h7);
    rd_chk(4'h2);
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic report_and_stop();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    rng = 32'haa10;
    {error_cnt, checked} = '0;
    {resetn, smp_valid, power_mode, vs, cs} = '0;
    ce = 1'b1;
    {ovth, oith, mthr, sum28, st0, st1, imsk, phst, cfg} = {24'(FS), 24'(FS), 181'h0};
    cal = '{default: 10'h0};
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk({31'h0, extref}, 32'h0);
    chk({31'h0, irq_n}, 32'h1);
    for (int a = 0; a < 13; a++) rd_chk(4'(a));
    done("reset values");
    for (int i = 0; i < 3; i++) begin
      w(4 + i, {22'h0, host.cal_code(steps[i])});
      rd_chk(4'(4 + i));
    end
    w(3, host.word24(24'hfffff0));
    rd_chk(4'h3);
    w(2, xs());
    w(12, xs());
    rd_chk(4'h2);
    rd_chk(4'hc);
    done("register words");
    w(3, host.word24(24'h7fffff));
    w(9, 32'h00060000);
    for (int t = 0; t < 3; t++) begin
      lvl = (t == 0) ? 24'h0 : (t == 1) ? 24'(FS) : 24'(32'h80000 + xs() % 32'h140000);
      w(0, host.word24(lvl));
      w(1, host.word24(lvl));
      rd_chk(4'h1);
      repeat (4) smp(1'b0);
      w(8, 32'hffffffff);
      chk({31'h0, irq_n}, 32'h1);
    end
    w(7, 32'h0002_0000);
    rd_chk(4'h7);
    done("level detection");
    w(0, host.word24(24'(FS)));
    w(1, host.word24(24'(FS)));
    w(9, 32'h00100000);
    for (int t = 0; t < 4; t++) begin
      w(3, host.word24(mt[t]));
      repeat (6) begin
        smp(1'b1);
        w(8, 32'h00100000);
        chk({31'h0, irq_n}, 32'h1);
      end
    end
    // phase a code gives the largest advance: a one-step lag, settled in a few steps
    repeat (400) @(posedge sys_clk);
    chk({8'h0, al[0]}, {8'h0, vs[0]});
    done("neutral mismatch");
    w(11, 32'h1);
    chk({31'h0, extref}, 32'h1);
    rd_chk(4'hb);
    @(posedge sys_clk);
    power_mode <= 2'h2;
    w(11, 32'h0);
    chk({31'h0, extref}, 32'h1);
    @(posedge sys_clk);
    power_mode <= 2'h0;
    w(11, 32'h0);
    chk({31'h0, extref}, 32'h0);
    // a write while the clock enable is low must not land
    @(posedge sys_clk);
    ce <= 1'b0;
    host.wr(4'hb, 32'h1);
    #1;
    chk({31'h0, extref}, 32'h0);
    @(posedge sys_clk);
    ce <= 1'b1;
    done("reference select");
    report_and_stop();
  end
  // watchdog, far beyond the roughly one thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule
